// file: rtl/trip_regs.svh
// register map, codes and timing constants for the fault trip recorder
`ifndef TRIP_REGS_SVH
`define TRIP_REGS_SVH
`define REG_INIT_SELECT    8'h00
`define REG_INIT_REGION    8'h04
`define REG_STATUS         8'h08
`define REG_DISPLAY        8'h0c
`define REG_NEWEST         8'h10
`define REG_PREVIOUS       8'h14
`define REG_OLDEST         8'h18
`define CODE_NONE          8'h00
`define CODE_OC_CONST      8'h01
`define CODE_OC_DECEL      8'h02
`define CODE_OC_ACCEL      8'h03
`define CODE_OC_OTHER      8'h04
`define CODE_OVERLOAD      8'h05
`define CODE_OVERVOLT      8'h07
`define CODE_NVM           8'h08
`define CODE_UNDERVOLT     8'h09
`define CODE_CPU           8'h11
`define CODE_EXT_TRIP      8'h12
`define SEL_CLEAR_HISTORY  8'h00
`define SEL_FULL_RESTORE   8'h01
`define REGION_JAPAN       8'h00
`define REGION_EUROPE      8'h01
`define REGION_USA         8'h02
`define INIT_SELECT_RESET  8'h00
`define INIT_REGION_RESET  8'h00
`define STAT_TRIPPED       0
`define STAT_MOTOR_EN      1
`define STAT_INIT_BUSY     2
`define STAT_NVM_MARK      3
`define STAT_CODE_LSB      8
`define DISP_BLINK_BIT     8
`define DISP_MODE_LSB      16
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10
`define CLK_KHZ            40000
`define INIT_HOLD_MS       1000
`define BLINK_MS           250
`endif

// file: rtl/trip_pkg.sv
// types shared by the fault trip recorder modules
package trip_pkg;
  typedef enum logic [1:0] {
    INIT_IDLE  = 2'b00,
    INIT_HOLD  = 2'b01,
    INIT_SHOW  = 2'b10,
    INIT_APPLY = 2'b11
  } init_state_type;
  typedef enum logic [1:0] {
    DISP_MONITOR = 2'b00,
    DISP_ERROR   = 2'b01,
    DISP_REGION  = 2'b10
  } disp_mode_type;
  typedef struct packed {
    logic [7:0]  code;
    logic [23:0] snap;
  } fault_entry_type;
endpackage : trip_pkg

// file: rtl/history_stack.sv
// three-deep fault history shift stack
module history_stack
  import trip_pkg::*;
#(
  parameter int DEPTH = 3
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        push,
  input  wire logic                        clear,
  input  wire fault_entry_type             new_entry,
  output fault_entry_type [DEPTH-1:0]      entries
);
  typedef struct packed {
    fault_entry_type [DEPTH-1:0] slot;
  } hist_state_type;

  hist_state_type s_q;
  hist_state_type s_d;

  always_comb begin
    s_d = s_q;
    if (clear) begin
      s_d.slot = '0;
    end
    // a fault pushed in the clear cycle survives the clear
    if (push) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        s_d.slot[i] = clear ? '0 : s_q.slot[i-1];
      end
      s_d.slot[0] = new_entry;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign entries = s_q.slot;
endmodule : history_stack

// file: rtl/drive_fault_trip_recorder.sv
// fault trip, display code, history and initialization control with AXI4-Lite registers
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`include "trip_regs.svh"

// Overview of operation
// - a fault while not tripped, or in a clear cycle, records a history entry and switches motor output off
// - trips are taken in stop mode as well as running
// - stop/reset key while tripped clears the active fault
// - init with select 00 erases history only, settings kept
// - a trip shows its error code on the display at once, or when the init region display ends
// - over-current code 01 constant, 02 decel, 03 accel, 04 otherwise
// - thermal overload trips with code 05, output off
// - bus over-voltage trips with code 07
// - parameter memory fault trips with code 08, output off
// - bus under-voltage trips with code 09, output off
// - processor malfunction trips with code 11, output off
// - external trip input trips with code 12, output off
// - power lost with fault clear input active gives code 08 on return
// - newest entry captures operating snapshot with the code
// - three entries; new fault shifts newest to middle, middle to oldest
// - region code picks defaults: 00 Japan, 01 Europe, 02 USA
// - select 01 arms full restore of all parameters
// - hold three keys until region shows, release, then monitor shown if not tripped
// - init key sequence only from built-in keypad, never remote
module drive_fault_trip_recorder
  import trip_pkg::*;
#(
  parameter int HOLD_CYCLES  = `INIT_HOLD_MS * `CLK_KHZ,
  parameter int BLINK_CYCLES = `BLINK_MS * `CLK_KHZ
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        over_current,
  input  wire logic        at_constant_speed,
  input  wire logic        decelerating,
  input  wire logic        accelerating,
  input  wire logic        thermal_overload,
  input  wire logic        bus_over_voltage,
  input  wire logic        nvm_fault,
  input  wire logic        bus_under_voltage,
  input  wire logic        cpu_fault,
  input  wire logic        external_trip_input,
  input  wire logic        fault_clear_input,
  input  wire logic        power_fail,
  input  wire logic        nvm_mark_at_boot,
  input  wire logic [23:0] operating_snapshot,
  input  wire logic        run_cmd,
  input  wire logic        stop_reset_key,
  input  wire logic        key_func,
  input  wire logic        key_up,
  input  wire logic        key_down,
  input  wire logic        keys_from_remote,
  output logic             motor_output_enable,
  output logic             nvm_mark,
  output logic [1:0]       display_mode,
  output logic [7:0]       display_value,
  output logic             display_blink,
  output logic             defaults_restore,
  output logic [7:0]       defaults_region
);
  typedef struct packed {
    logic           tripped;
    logic [7:0]     code;
    logic           run_block;
    logic           boot_done;
    logic           nvm_mark;
    init_state_type init_state;
    logic [31:0]    hold_cnt;
    logic [31:0]    blink_cnt;
    logic           blink;
    logic [7:0]     select;
    logic [7:0]     region;
    logic           restore;
    logic           motor_en;
    disp_mode_type  disp_mode;
    logic [7:0]     disp_value;
    logic [7:0]     awaddr;
    logic           aw_full;
    logic [31:0]    wdata;
    logic [3:0]     wstrb;
    logic           w_full;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           rvalid;
    logic [31:0]    rdata;
    logic [1:0]     rresp;
  } state_type;

  state_type                 s_q;
  state_type                 s_d;
  fault_entry_type [2:0]     hist;
  fault_entry_type           new_entry;
  logic                      nvm_boot;
  logic                      fault_now;
  logic [7:0]                code_now;
  logic                      clear_req;
  logic                      take;
  logic                      combo;
  logic                      any_key;
  logic                      hist_clear;
  logic [7:0]                wsel;
  logic [7:0]                wreg;

  // fixed priority when several faults rise in one cycle
  function automatic logic [7:0] fault_code(
    input logic oc,
    input logic cs,
    input logic dc,
    input logic ac,
    input logic ol,
    input logic ov,
    input logic nv,
    input logic uv,
    input logic cp,
    input logic ex
  );
    logic [7:0] c;
    c = `CODE_NONE;
    if (ex) c = `CODE_EXT_TRIP;
    if (ol) c = `CODE_OVERLOAD;
    if (ov) c = `CODE_OVERVOLT;
    if (uv) c = `CODE_UNDERVOLT;
    if (oc) begin
      case ({cs, dc, ac})
        3'b100:  c = `CODE_OC_CONST;
        3'b010:  c = `CODE_OC_DECEL;
        3'b001:  c = `CODE_OC_ACCEL;
        default: c = `CODE_OC_OTHER;
      endcase
    end
    if (nv) c = `CODE_NVM;
    if (cp) c = `CODE_CPU;
    return c;
  endfunction : fault_code

  // byte-lane merge for the two writable registers
  function automatic logic [7:0] lane0(
    input logic [7:0]  old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    return strb[0] ? data[7:0] : old;
  endfunction : lane0

  assign nvm_boot  = !s_q.boot_done && nvm_mark_at_boot;
  assign fault_now = over_current | thermal_overload | bus_over_voltage | nvm_fault
                   | bus_under_voltage | cpu_fault | external_trip_input | nvm_boot;
  assign code_now  = fault_code(over_current, at_constant_speed, decelerating, accelerating,
                                thermal_overload, bus_over_voltage, nvm_fault | nvm_boot,
                                bus_under_voltage, cpu_fault, external_trip_input);
  assign clear_req = stop_reset_key | fault_clear_input;
  // no gating on run state: a stopped drive trips too
  assign take      = fault_now && (!s_q.tripped || clear_req);
  assign combo     = key_func & key_up & key_down & !keys_from_remote;
  assign any_key   = key_func | key_up | key_down;
  assign hist_clear = (s_q.init_state == INIT_APPLY);
  assign new_entry = '{code: code_now, snap: operating_snapshot};
  assign wsel      = s_q.awaddr & 8'hfc;

  always_comb begin
    s_d = s_q;
    s_d.restore = 1'b0;
    s_d.boot_done = 1'b1;
    wreg = 8'h00;

    // trip and clear; a fault present in the clear cycle wins
    if (s_q.tripped && clear_req) begin
      s_d.tripped = 1'b0;
    end
    if (take) begin
      s_d.tripped = 1'b1;
      s_d.code = code_now;
      s_d.run_block = 1'b1;
    end
    if (!s_d.tripped && !run_cmd) begin
      s_d.run_block = 1'b0;
    end
    if (power_fail && fault_clear_input) begin
      s_d.nvm_mark = 1'b1;
    end

    // blink divider
    if (s_q.blink_cnt == 32'(BLINK_CYCLES - 1)) begin
      s_d.blink_cnt = 32'h0000_0000;
      s_d.blink = !s_q.blink;
    end else begin
      s_d.blink_cnt = s_q.blink_cnt + 32'h0000_0001;
    end

    // initialization key sequence
    case (s_q.init_state)
      INIT_IDLE: begin
        if (combo && (s_q.select == `SEL_CLEAR_HISTORY ||
                      s_q.select == `SEL_FULL_RESTORE)) begin
          s_d.init_state = INIT_HOLD;
          s_d.hold_cnt = 32'h0000_0000;
        end
      end
      INIT_HOLD: begin
        // released early: nothing happens
        if (!combo) begin
          s_d.init_state = INIT_IDLE;
        end else if (s_q.hold_cnt == 32'(HOLD_CYCLES - 1)) begin
          s_d.init_state = INIT_SHOW;
        end else begin
          s_d.hold_cnt = s_q.hold_cnt + 32'h0000_0001;
        end
      end
      INIT_SHOW: begin
        if (keys_from_remote) begin
          s_d.init_state = INIT_IDLE;
        end else if (!any_key) begin
          s_d.init_state = INIT_APPLY;
        end
      end
      INIT_APPLY: begin
        if (s_q.select == `SEL_FULL_RESTORE) begin
          s_d.restore = 1'b1;
          s_d.select = `INIT_SELECT_RESET;
        end
        s_d.init_state = INIT_IDLE;
      end
      default: begin
        s_d.init_state = INIT_IDLE;
      end
    endcase

    s_d.motor_en = !s_d.tripped && !s_d.run_block && run_cmd &&
                   (s_d.init_state == INIT_IDLE);

    // display: init region first, then error code, else frequency monitor
    if (s_d.init_state == INIT_SHOW || s_d.init_state == INIT_APPLY) begin
      s_d.disp_mode = DISP_REGION;
      s_d.disp_value = s_q.region;
    end else if (s_d.tripped) begin
      s_d.disp_mode = DISP_ERROR;
      s_d.disp_value = s_d.code;
    end else begin
      s_d.disp_mode = DISP_MONITOR;
      s_d.disp_value = 8'h00;
    end

    // write channel: address and data taken in either order
    if (s_axi_awvalid && !s_q.aw_full) begin
      s_d.aw_full = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_full) begin
      s_d.w_full = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `RESP_OKAY;
      case (wsel)
        `REG_INIT_SELECT: begin
          s_d.select = lane0(s_q.select, s_q.wdata, s_q.wstrb);
        end
        `REG_INIT_REGION: begin
          wreg = lane0(s_q.region, s_q.wdata, s_q.wstrb);
          // codes beyond the three regions are kept out
          if (wreg <= `REGION_USA) begin
            s_d.region = wreg;
          end
        end
        `REG_STATUS, `REG_DISPLAY, `REG_NEWEST, `REG_PREVIOUS, `REG_OLDEST: begin
          s_d.bresp = `RESP_OKAY;
        end
        default: begin
          s_d.bresp = `RESP_SLVERR;
        end
      endcase
    end

    // read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `RESP_OKAY;
      s_d.rdata = 32'h0000_0000;
      case (s_axi_araddr & 8'hfc)
        `REG_INIT_SELECT: s_d.rdata[7:0] = s_q.select;
        `REG_INIT_REGION: s_d.rdata[7:0] = s_q.region;
        `REG_STATUS: begin
          s_d.rdata[`STAT_TRIPPED] = s_q.tripped;
          s_d.rdata[`STAT_MOTOR_EN] = s_q.motor_en;
          s_d.rdata[`STAT_INIT_BUSY] = (s_q.init_state != INIT_IDLE);
          s_d.rdata[`STAT_NVM_MARK] = s_q.nvm_mark;
          s_d.rdata[`STAT_CODE_LSB +: 8] = s_q.tripped ? s_q.code : `CODE_NONE;
        end
        `REG_DISPLAY: begin
          s_d.rdata[7:0] = s_q.disp_value;
          s_d.rdata[`DISP_BLINK_BIT] = display_blink;
          s_d.rdata[`DISP_MODE_LSB +: 2] = s_q.disp_mode;
        end
        `REG_NEWEST:   s_d.rdata = hist[0];
        `REG_PREVIOUS: s_d.rdata = hist[1];
        `REG_OLDEST:   s_d.rdata = hist[2];
        default:       s_d.rresp = `RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.select <= `INIT_SELECT_RESET;
      s_q.region <= `INIT_REGION_RESET;
      s_q.init_state <= INIT_IDLE;
      s_q.disp_mode <= DISP_MONITOR;
    end else begin
      s_q <= s_d;
    end
  end

  history_stack #(
    .DEPTH     (3)
  ) u_history (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .push      (take),
    .clear     (hist_clear),
    .new_entry (new_entry),
    .entries   (hist)
  );

  assign s_axi_awready       = !s_q.aw_full;
  assign s_axi_wready        = !s_q.w_full;
  assign s_axi_bvalid        = s_q.bvalid;
  assign s_axi_bresp         = s_q.bresp;
  assign s_axi_arready       = !s_q.rvalid;
  assign s_axi_rvalid        = s_q.rvalid;
  assign s_axi_rdata         = s_q.rdata;
  assign s_axi_rresp         = s_q.rresp;
  assign motor_output_enable = s_q.motor_en;
  assign nvm_mark            = s_q.nvm_mark;
  assign display_mode        = s_q.disp_mode;
  assign display_value       = s_q.disp_value;
  // only the leftmost character alternates, only while region shows
  assign display_blink       = s_q.blink && (s_q.disp_mode == DISP_REGION);
  assign defaults_restore    = s_q.restore;
  assign defaults_region     = s_q.region;
endmodule : drive_fault_trip_recorder

// file: dv/trip_props.sv
// concurrent checks on the fault trip recorder ports
module trip_props
  import trip_pkg::*;
#(
  parameter int HOLD_CYCLES  = 8,
  parameter int BLINK_CYCLES = 4
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       over_current,
  input wire logic       at_constant_speed,
  input wire logic       decelerating,
  input wire logic       accelerating,
  input wire logic       thermal_overload,
  input wire logic       bus_over_voltage,
  input wire logic       nvm_fault,
  input wire logic       bus_under_voltage,
  input wire logic       cpu_fault,
  input wire logic       external_trip_input,
  input wire logic       fault_clear_input,
  input wire logic       power_fail,
  input wire logic       stop_reset_key,
  input wire logic       key_func,
  input wire logic       key_up,
  input wire logic       key_down,
  input wire logic       keys_from_remote,
  input wire logic       motor_output_enable,
  input wire logic       nvm_mark,
  input wire logic [1:0] display_mode,
  input wire logic [7:0] display_value,
  input wire logic       display_blink,
  input wire logic       defaults_restore,
  input wire logic [7:0] defaults_region
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       any_fault;
  logic       blink_last;
  int         stay_q;
  logic [7:0] exp_code;
  int         hold_d;
  int         hold_q;
  // expected code by the fixed fault priority
  always_comb begin
    any_fault = over_current | thermal_overload | bus_over_voltage | nvm_fault |
                bus_under_voltage | cpu_fault | external_trip_input;
    hold_d = (key_func & key_up & key_down & !keys_from_remote) ? hold_q + 1 : 0;
    if (cpu_fault) exp_code = 8'h11;
    else if (nvm_fault) exp_code = 8'h08;
    else if (over_current) begin
      if ($countones({at_constant_speed, decelerating, accelerating}) != 1) exp_code = 8'h04;
      else exp_code = accelerating ? 8'h03 : (decelerating ? 8'h02 : 8'h01);
    end
    else if (bus_under_voltage) exp_code = 8'h09;
    else if (bus_over_voltage) exp_code = 8'h07;
    else if (thermal_overload) exp_code = 8'h05;
    else exp_code = 8'h12;
  end
  // remote keys restart the count, so a remote hold never reaches the limit
  always_ff @(posedge aclk) begin
    hold_q <= aresetn ? hold_d : 0;
  end
  // a stuck blink shows as a long run of one value while the region is up
  always_ff @(posedge aclk) begin
    blink_last <= display_blink;
    if (!aresetn || display_mode != DISP_REGION || display_blink != blink_last) begin
      stay_q <= 0;
    end else begin
      stay_q <= stay_q + 1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_trip_off; any_fault |=> !motor_output_enable; endproperty
  a_trip_off: assert property (p_trip_off) else $error("output on after fault");
  property p_code;
    motor_output_enable && any_fault && !stop_reset_key && !fault_clear_input
      |=> display_mode == DISP_ERROR && display_value == $past(exp_code);
  endproperty
  a_code: assert property (p_code) else $error("wrong trip code");
  property p_hold_off;
    !motor_output_enable && display_mode == DISP_ERROR && !stop_reset_key && !fault_clear_input
      |=> !motor_output_enable;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("output on while tripped");
  property p_clear;
    display_mode == DISP_ERROR && stop_reset_key && !any_fault |=> display_mode == DISP_MONITOR;
  endproperty
  a_clear: assert property (p_clear) else $error("stop key did not clear");
  property p_nvm_set; power_fail && fault_clear_input |=> nvm_mark; endproperty
  a_nvm_set: assert property (p_nvm_set) else $error("memory mark not set");
  property p_nvm_keep; nvm_mark |=> $stable(nvm_mark); endproperty
  a_nvm_keep: assert property (p_nvm_keep) else $error("memory mark lost");
  property p_blink; display_blink |-> display_mode == DISP_REGION; endproperty
  a_blink: assert property (p_blink) else $error("blink outside region display");
  property p_blink_rate; stay_q <= BLINK_CYCLES; endproperty
  a_blink_rate: assert property (p_blink_rate) else $error("region blink stuck");
  property p_pulse; defaults_restore |=> !defaults_restore; endproperty
  a_pulse: assert property (p_pulse) else $error("restore pulse too long");
  property p_region_ok; defaults_restore |-> defaults_region <= 8'h02; endproperty
  a_region_ok: assert property (p_region_ok) else $error("bad restore region");
  property p_hold; $rose(display_mode == DISP_REGION) |-> hold_q >= HOLD_CYCLES; endproperty
  a_hold: assert property (p_hold) else $error("region shown too early");
endmodule : trip_props

bind drive_fault_trip_recorder trip_props #(
  .HOLD_CYCLES  (HOLD_CYCLES),
  .BLINK_CYCLES (BLINK_CYCLES)
) u_props (.*);

// file: dv/operator_panel_model.sv
// built-in keypad model playing the three-key initialization sequence
module operator_panel_model
  import trip_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic [1:0] display_mode,
  output logic            key_func,
  output logic            key_up,
  output logic            key_down
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {key_func, key_up, key_down} = 3'b000;
  // release once the region shows or the limit runs out; an early release aborts
  task automatic run_init(input int limit, output logic shown);
    int n;
    shown = 1'b0;
    n = 0;
    {key_func, key_up, key_down} <= 3'b111;
    while (!shown && n < limit) begin
      @(posedge aclk);
      n++;
      shown = (display_mode === DISP_REGION);
    end
    // a real hand lingers a little; keeps the region up long enough to blink
    if (shown) repeat (6) @(posedge aclk);
    {key_func, key_up, key_down} <= 3'b000;
    repeat (4) @(posedge aclk);
  endtask : run_init
endmodule : operator_panel_model

// file: dv/testbench.sv
// self-checking bench for the fault trip recorder
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b1;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b1;
  logic [9:0]  flt = 10'h000;
  logic        over_current, at_constant_speed, decelerating, accelerating, thermal_overload;
  logic        bus_over_voltage, nvm_fault, bus_under_voltage, cpu_fault, external_trip_input;
  logic        fault_clear_input = 1'b0;
  logic        power_fail = 1'b0;
  logic        nvm_mark_at_boot = 1'b0;
  logic [23:0] operating_snapshot = 24'h0;
  logic        run_cmd = 1'b0;
  logic        stop_reset_key = 1'b0;
  logic        keys_from_remote = 1'b0;
  logic        key_func, key_up, key_down;
  logic        motor_output_enable, nvm_mark, display_blink, defaults_restore;
  logic [1:0]  display_mode;
  logic [7:0]  display_value, defaults_region;
  logic [8:0]  rest_seen = 9'h0;
  logic [7:0]  region_seen = 8'h0;
  logic [31:0] hist [3] = '{default: 32'h0};
  logic [31:0] d;
  logic [1:0]  r;
  logic        sh;
  logic [9:0]  fv [10] = '{10'h002, 10'h300, 10'h280, 10'h240, 10'h200,
                           10'h020, 10'h010, 10'h008, 10'h004, 10'h001};
  logic [7:0]  fc [10] = '{8'h11, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h12};
  int          errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  assign {over_current, at_constant_speed, decelerating, accelerating, thermal_overload,
          bus_over_voltage, nvm_fault, bus_under_voltage, cpu_fault, external_trip_input} = flt;
  // short counts keep the key hold within a few cycles
  drive_fault_trip_recorder #(.HOLD_CYCLES(8), .BLINK_CYCLES(4)) u_dut (.*);
  operator_panel_model u_panel (
    .aclk         (aclk),
    .display_mode (display_mode),
    .key_func     (key_func),
    .key_up       (key_up),
    .key_down     (key_down)
  );
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (defaults_restore === 1'b1) rest_seen <= {1'b1, defaults_region};
    if (display_mode === 2'b10) region_seen <= display_value;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors++;
      finish_test();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // ready lines stay high, so the answer is taken at the edge it is seen
  task wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask : wr
  task rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
  task finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h00); chk(d, 32'h0);
    rd(8'h04); chk(d, 32'h0);
    rd(8'h1c); chk({r, d[29:0]}, 32'h80000000);
    wr(8'h1c, 32'h1); chk(r, 2'b10);
    for (int i = 0; i < 10; i++) begin
      if (i > 0) begin
        run_cmd <= 1'b0;
        @(posedge aclk);
        run_cmd <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(motor_output_enable, 1'b1);
      end
      operating_snapshot <= {16'h5a00, 8'(i)};
      flt <= fv[i];
      @(posedge aclk);
      flt <= 10'h000;
      repeat (2) @(posedge aclk);
      chk(motor_output_enable, 1'b0);
      chk({display_mode, display_value}, {2'b01, fc[i]});
      rd(8'h0c); chk(d, {14'h0, 2'b01, 8'h00, fc[i]});
      rd(8'h08); chk(d[15:0], {fc[i], 8'h01});
      hist[2] = hist[1];
      hist[1] = hist[0];
      hist[0] = {fc[i], 16'h5a00, 8'(i)};
      for (int k = 0; k < 3; k++) begin
        rd(8'h10 + 8'(4 * k)); chk(d, hist[k]);
      end
      if (i % 2) fault_clear_input <= 1'b1;
      else stop_reset_key <= 1'b1;
      @(posedge aclk);
      fault_clear_input <= 1'b0;
      stop_reset_key <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(motor_output_enable, 1'b0);
      rd(8'h08); chk(d[0], 1'b0);
    end
    wr(8'h04, 32'h1);
    wr(8'h04, 32'h3);
    rd(8'h04); chk(d, 32'h1);
    s_axi_wstrb <= 4'he;
    wr(8'h04, 32'h0);
    s_axi_wstrb <= 4'hf;
    rd(8'h04); chk(d, 32'h1);
    wr(8'h00, 32'h0);
    u_panel.run_init(40, sh); chk(sh, 1'b1);
    chk(display_mode, 2'b00);
    chk(rest_seen, 9'h000);
    rd(8'h04); chk(d, 32'h1);
    for (int k = 0; k < 3; k++) begin
      rd(8'h10 + 8'(4 * k)); chk(d, 32'h0);
    end
    wr(8'h04, 32'h2);
    wr(8'h00, 32'h1);
    u_panel.run_init(40, sh);
    chk(rest_seen, 9'h102);
    chk(region_seen, 8'h02);
    rd(8'h00); chk(d, 32'h0);
    keys_from_remote <= 1'b1;
    u_panel.run_init(30, sh); chk(sh, 1'b0);
    keys_from_remote <= 1'b0;
    fault_clear_input <= 1'b1;
    power_fail <= 1'b1;
    @(posedge aclk);
    fault_clear_input <= 1'b0;
    power_fail <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(nvm_mark, 1'b1);
    aresetn <= 1'b0;
    nvm_mark_at_boot <= 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    nvm_mark_at_boot <= 1'b0;
    rd(8'h08); chk(d[15:0], 16'h0801);
    finish_test();
  end
endmodule : testbench
